// >>> tbp_trace_buffer.sv
// trace buffer writer with pointer checks and register slave
`timescale 1ns/1ps
`include "tbp_defines.svh"
module tbp_trace_buffer #(
    parameter int ALIGN_LOG2 = 2
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // trace source
    input wire logic trace_valid,
    input wire logic [31:0] trace_data,
    output logic trace_ready,
    input wire logic trace_trigger,
    // owning context
    input wire logic [15:0] owner_partid,
    input wire logic [7:0] owner_pmg,
    input wire logic owner_ns,
    input wire logic owner_stage2,
    // memory write port
    output logic mem_req,
    output tbp_pkg::tbp_addr_t mem_addr,
    output logic [31:0] mem_data,
    output logic [1:0] mem_space,
    output logic [7:0] mem_attr,
    output logic [15:0] mem_partid,
    output logic [7:0] mem_pmg,
    output logic mem_ns,
    output logic mem_tag_unchecked,
    input wire logic mem_ack,
    input wire logic [1:0] mem_resp,
    // events
    output logic wrap_event_output,
    output logic buffer_interrupt_output
);
    import tbp_pkg::*;

    // ========================================
    // registers and checks
    tbp_addr_t ptr_q, base_q, lim_q, amask;
    logic [31:0] trg_q;
    logic [7:0] mar_q, wr_addr_q;
    logic [3:0] fm_q;
    logic en_q, phys_q, s_q, ea_q, wrap_q, irq_q;
    logic [5:0] ec_q;
    logic [15:0] mss_q;
    logic init_ok_q, fault_hit_q, trig_det_q, wr_pend_q;
    logic [31:0] hrdata_q, rd_mux;
    tbp_state_e state_q;
    tbp_addr_t addr_q, nxt_ptr;
    logic running, oor, mis, trg_mis, ahb_take, sw_ok;
    logic start, align_evt, done, ok_done, wrap_hit, trig_hit, evt;
    logic [5:0] evt_ec;
    logic restart_val, fault_val;
    tbp_addr_t ld_ptr;
    logic ld_ok;

    assign amask = ~(~64'h0 << ALIGN_LOG2);
    assign oor = (ptr_q < base_q) || (ptr_q >= lim_q) ||
                 (ptr_q[63:56] != base_q[63:56]) ||
                 (ptr_q[63:56] != lim_q[63:56]);
    assign mis = |(ptr_q & amask);
    assign trg_mis = |(trg_q & amask[31:0]);
    assign running = en_q & ~s_q;
    // both flags need the engine idle, i.e. all writes complete
    assign restart_val = init_ok_q & ~en_q & (state_q == TBP_IDLE) &
                         ~fault_hit_q & ~ea_q;
    assign fault_val = init_ok_q & ~en_q & (state_q == TBP_IDLE) &
                       (fault_hit_q | ea_q);
    // judge the pointer as it will stand once the high word lands
    assign ld_ptr = {hwdata, ptr_q[31:0]};
    assign ld_ok = ~|(ld_ptr & amask) && (ld_ptr >= base_q) &&
                   (ld_ptr < lim_q) && (ld_ptr[63:56] == base_q[63:56]) &&
                   (ld_ptr[63:56] == lim_q[63:56]);

    // ========================================
    // ahb-lite slave, zero wait states
    assign ahb_take = hsel & htrans[1] & hready;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;
    // while enabled only the enable-bearing limit word is honoured
    assign sw_ok = wr_pend_q & (~en_q | (wr_addr_q == `TBP_OFF_LIM_LO));

    always_comb begin
        case (haddr[7:0])
            `TBP_OFF_PTR_LO: rd_mux = ptr_q[31:0];
            `TBP_OFF_PTR_HI: rd_mux = ptr_q[63:32];
            `TBP_OFF_BASE_LO: rd_mux = base_q[31:0];
            `TBP_OFF_BASE_HI: rd_mux = base_q[63:32];
            `TBP_OFF_LIM_LO: rd_mux = {lim_q[31:12], 6'h0, phys_q,
                                       fm_q, en_q};
            `TBP_OFF_LIM_HI: rd_mux = lim_q[63:32];
            `TBP_OFF_TRG: rd_mux = trg_q;
            `TBP_OFF_STAT: rd_mux = {ec_q, 3'h0, irq_q, 2'h0, wrap_q, ea_q,
                                     s_q, 7'h0, fault_val, restart_val,
                                     mss_q[7:0]};
            `TBP_OFF_MAR: rd_mux = {24'h0, mar_q};
            `TBP_OFF_ID: rd_mux = ALIGN_LOG2[31:0];
            default: rd_mux = `TBP_RST_W32;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= `TBP_RST_W8;
            hrdata_q <= `TBP_RST_W32;
        end else begin
            wr_pend_q <= ahb_take & hwrite;
            if (ahb_take)
                wr_addr_q <= haddr[7:0];
            if (ahb_take && !hwrite)
                hrdata_q <= rd_mux;
        end
    end

    // ========================================
    // control registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            base_q <= 64'h0;
            lim_q <= 64'h0;
            en_q <= 1'b0;
            phys_q <= 1'b0;
            fm_q <= 4'h0;
            mar_q <= `TBP_RST_W8;
        end else if (sw_ok) begin
            case (wr_addr_q)
                `TBP_OFF_BASE_LO: base_q[31:0] <= {hwdata[31:12], 12'h0};
                `TBP_OFF_BASE_HI: base_q[63:32] <= hwdata;
                `TBP_OFF_LIM_LO: begin
                    en_q <= hwdata[`TBP_LIM_EN];
                    if (!en_q) begin
                        lim_q[31:0] <= {hwdata[31:12], 12'h0};
                        phys_q <= hwdata[`TBP_LIM_PHYS];
                        fm_q <= hwdata[4:1];
                    end
                end
                `TBP_OFF_LIM_HI: lim_q[63:32] <= hwdata;
                `TBP_OFF_MAR: mar_q <= hwdata[7:0];
                default: ;
            endcase
        end
    end

    // ========================================
    // write engine, one word in flight
    assign trace_ready = ~running | (state_q == TBP_IDLE);
    assign start = running & trace_valid & (state_q == TBP_IDLE) & ~mis;
    assign align_evt = running & trace_valid & (state_q == TBP_IDLE) &
                       mis & ~restart_val;
    assign done = (state_q == TBP_WRITE) & mem_ack;
    assign ok_done = done & (mem_resp == `TBP_RESP_OK);
    assign nxt_ptr = addr_q + `TBP_STEP;
    assign wrap_hit = ok_done & (nxt_ptr >= lim_q);
    assign trig_hit = ok_done & trig_det_q & (trg_q <= 32'h4);
    assign evt = align_evt | (done & ~ok_done) | wrap_hit | trig_hit;

    always_comb begin
        if (align_evt)
            evt_ec = `TBP_EC_ALIGN;
        else if (done && mem_resp == `TBP_RESP_XLAT)
            evt_ec = `TBP_EC_MMU;
        else if (done && !ok_done)
            evt_ec = `TBP_EC_ABORT;
        else if (wrap_hit)
            evt_ec = `TBP_EC_WRAP;
        else
            evt_ec = `TBP_EC_TRIG;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= TBP_IDLE;
            addr_q <= 64'h0;
            mem_data <= `TBP_RST_W32;
            mem_space <= `TBP_SP_VA;
            mem_attr <= `TBP_RST_W8;
            mem_partid <= 16'h0;
            mem_pmg <= 8'h0;
            mem_ns <= 1'b0;
        end else begin
            case (state_q)
                TBP_IDLE: begin
                    if (start) begin
                        state_q <= TBP_WRITE;
                        addr_q <= oor ? base_q : ptr_q;
                        mem_data <= trace_data;
                        mem_space <= !phys_q ? `TBP_SP_VA :
                                     owner_stage2 ? `TBP_SP_IPA :
                                     `TBP_SP_PA;
                        mem_attr <= mar_q;
                        mem_partid <= owner_partid;
                        mem_pmg <= owner_pmg;
                        mem_ns <= owner_ns;
                    end
                end
                TBP_WRITE: begin
                    if (mem_ack)
                        state_q <= TBP_IDLE;
                end
                default: state_q <= TBP_IDLE;
            endcase
        end
    end

    assign mem_req = (state_q == TBP_WRITE);
    assign mem_addr = addr_q;
    assign mem_tag_unchecked = 1'b1;

    // ========================================
    // write pointer and restart tracking
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ptr_q <= 64'h0;
        end else if (sw_ok && wr_addr_q == `TBP_OFF_PTR_LO) begin
            ptr_q[31:0] <= hwdata;
        end else if (sw_ok && wr_addr_q == `TBP_OFF_PTR_HI) begin
            ptr_q[63:32] <= hwdata;
        end else if (start && oor) begin
            ptr_q <= base_q;
        end else if (done && !ok_done) begin
            ptr_q <= addr_q;
        end else if (ok_done) begin
            ptr_q <= wrap_hit ? base_q : nxt_ptr;
        end else if (align_evt && oor) begin
            ptr_q <= base_q;
        end
    end

    // an aligned pointer written while base/limit make it valid arms tracking
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            init_ok_q <= 1'b0;
            fault_hit_q <= 1'b0;
        end else begin
            if (sw_ok && wr_addr_q == `TBP_OFF_PTR_HI)
                init_ok_q <= ld_ok;
            if (align_evt || (done && mem_resp == `TBP_RESP_SERR))
                fault_hit_q <= 1'b1;
            else if (sw_ok && wr_addr_q == `TBP_OFF_PTR_LO)
                fault_hit_q <= 1'b0;
        end
    end

    // ========================================
    // trigger countdown
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            trg_q <= `TBP_RST_W32;
            trig_det_q <= 1'b0;
        end else begin
            if (sw_ok && wr_addr_q == `TBP_OFF_TRG) begin
                trg_q <= hwdata;
                trig_det_q <= 1'b0;
            end else begin
                if (running && trace_trigger)
                    trig_det_q <= 1'b1;
                // a misaligned count only steps down to the next lower boundary
                if (ok_done && trig_det_q && !trg_mis)
                    trg_q <= trig_hit ? 32'h0 : trg_q - 32'h4;
                else if (ok_done && trig_det_q)
                    trg_q <= trg_q & ~amask[31:0];
            end
        end
    end

    // ========================================
    // status, hardware set wins over software write
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q <= 1'b0;
            ea_q <= 1'b0;
            wrap_q <= 1'b0;
            irq_q <= 1'b0;
            ec_q <= 6'h0;
            mss_q <= 16'h0;
        end else begin
            if (sw_ok && wr_addr_q == `TBP_OFF_STAT) begin
                s_q <= hwdata[`TBP_ST_S];
                ea_q <= hwdata[`TBP_ST_EA];
                wrap_q <= hwdata[`TBP_ST_WRAP];
                irq_q <= hwdata[`TBP_ST_IRQ];
                ec_q <= hwdata[`TBP_ST_EC_LSB +: 6];
                mss_q <= {8'h0, hwdata[7:0]};
            end
            if (evt) begin
                s_q <= 1'b1;
                irq_q <= 1'b1;
                ec_q <= evt_ec;
                mss_q <= {14'h0, mem_resp};
            end
            if (done && (mem_resp == `TBP_RESP_ABORT ||
                         mem_resp == `TBP_RESP_SERR))
                ea_q <= 1'b1;
            if (wrap_hit || (start && oor))
                wrap_q <= 1'b1;
        end
    end

    // ========================================
    // event outputs
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            wrap_event_output <= 1'b0;
        else
            wrap_event_output <= wrap_hit | (start & oor);
    end

    assign buffer_interrupt_output = irq_q;
endmodule

// >>> tbp_defines.svh
// register map, field positions, reset values and codes of the trace buffer
`ifndef TBP_DEFINES_SVH
`define TBP_DEFINES_SVH
// ========================================
// register offsets
`define TBP_OFF_PTR_LO 8'h00
`define TBP_OFF_PTR_HI 8'h04
`define TBP_OFF_BASE_LO 8'h08
`define TBP_OFF_BASE_HI 8'h0c
`define TBP_OFF_LIM_LO 8'h10
`define TBP_OFF_LIM_HI 8'h14
`define TBP_OFF_TRG 8'h18
`define TBP_OFF_STAT 8'h1c
`define TBP_OFF_MAR 8'h20
`define TBP_OFF_ID 8'h24
// ========================================
// field positions
`define TBP_LIM_EN 0
`define TBP_LIM_PHYS 5
`define TBP_ST_RESTART 8
`define TBP_ST_FAULT 9
`define TBP_ST_S 17
`define TBP_ST_EA 18
`define TBP_ST_WRAP 19
`define TBP_ST_IRQ 22
`define TBP_ST_EC_LSB 26
// ========================================
// reset values and codes
`define TBP_RST_W32 32'h0000_0000
`define TBP_RST_W8 8'h00
`define TBP_STEP 64'h0000_0000_0000_0004
`define TBP_EC_WRAP 6'h01
`define TBP_EC_ALIGN 6'h02
`define TBP_EC_ABORT 6'h03
`define TBP_EC_MMU 6'h04
`define TBP_EC_TRIG 6'h05
`define TBP_RESP_OK 2'h0
`define TBP_RESP_ABORT 2'h1
`define TBP_RESP_XLAT 2'h2
`define TBP_RESP_SERR 2'h3
`define TBP_SP_VA 2'h0
`define TBP_SP_IPA 2'h1
`define TBP_SP_PA 2'h2
`endif

// >>> tbp_pkg.sv
// types shared by the trace buffer pointer logic
package tbp_pkg;
    typedef enum logic {TBP_IDLE, TBP_WRITE} tbp_state_e;
    typedef logic [63:0] tbp_addr_t;
endpackage

// >>> tbp_trace_buffer_props.sv
// port assertions of the trace buffer writer
`timescale 1ns/1ps
`include "tbp_defines.svh"
module tbp_trace_buffer_props #(
    parameter int ALIGN_LOG2 = 2
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // owning context
    input wire logic [15:0] owner_partid,
    input wire logic [7:0] owner_pmg,
    input wire logic owner_ns,
    input wire logic owner_stage2,
    // memory write port
    input wire logic mem_req,
    input wire tbp_pkg::tbp_addr_t mem_addr,
    input wire logic [1:0] mem_space,
    input wire logic [15:0] mem_partid,
    input wire logic [7:0] mem_pmg,
    input wire logic mem_ns,
    input wire logic mem_tag_unchecked,
    input wire logic mem_ack,
    input wire logic [1:0] mem_resp,
    // events
    input wire logic wrap_event_output,
    input wire logic buffer_interrupt_output
);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    // ========================================
    // memory write attributes
    property p_untag;
        mem_tag_unchecked;
    endproperty
    a_untag: assert property (p_untag) else $error("tag check on");
    property p_owner;
        $rose(mem_req) |-> mem_partid == $past(owner_partid) &&
            mem_pmg == $past(owner_pmg) && mem_ns == $past(owner_ns);
    endproperty
    a_owner: assert property (p_owner) else $error("owner ids");
    property p_hold;
        mem_req && !mem_ack |=> mem_req && $stable(mem_addr) &&
            $stable(mem_partid);
    endproperty
    a_hold: assert property (p_hold) else $error("write unstable");
    property p_space;
        $rose(mem_req) && mem_space != `TBP_SP_VA |-> mem_space ==
            ($past(owner_stage2) ? `TBP_SP_IPA : `TBP_SP_PA);
    endproperty
    a_space: assert property (p_space) else $error("address space");
    property p_align;
        $rose(mem_req) |-> (mem_addr & ((64'h1 << ALIGN_LOG2) - 64'h1)) == 0;
    endproperty
    a_align: assert property (p_align) else $error("misaligned write");
    // ========================================
    // events
    property p_wrap;
        wrap_event_output |-> $rose(mem_req) || $fell(mem_req);
    endproperty
    a_wrap: assert property (p_wrap) else $error("stray wrap pulse");
    property p_irq;
        mem_req && mem_ack && mem_resp != `TBP_RESP_OK |=>
            buffer_interrupt_output [*2];
    endproperty
    a_irq: assert property (p_irq) else $error("no interrupt");
    property p_stop;
        mem_req && mem_ack && mem_resp != `TBP_RESP_OK |=> !mem_req [*8];
    endproperty
    a_stop: assert property (p_stop) else $error("still collecting");
endmodule

bind tbp_trace_buffer tbp_trace_buffer_props #(.ALIGN_LOG2(ALIGN_LOG2))
    u_props (
    .hclk(hclk),
    .hresetn(hresetn),
    .owner_partid(owner_partid),
    .owner_pmg(owner_pmg),
    .owner_ns(owner_ns),
    .owner_stage2(owner_stage2),
    .mem_req(mem_req),
    .mem_addr(mem_addr),
    .mem_space(mem_space),
    .mem_partid(mem_partid),
    .mem_pmg(mem_pmg),
    .mem_ns(mem_ns),
    .mem_tag_unchecked(mem_tag_unchecked),
    .mem_ack(mem_ack),
    .mem_resp(mem_resp),
    .wrap_event_output(wrap_event_output),
    .buffer_interrupt_output(buffer_interrupt_output)
);

// >>> tbp_mem_model.sv
// memory side of the trace buffer: acknowledges and logs writes
`timescale 1ns/1ps
module tbp_mem_model (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // memory write port
    input wire logic mem_req,
    input wire logic [63:0] mem_addr,
    input wire logic [31:0] mem_data,
    output logic mem_ack,
    output logic [1:0] mem_resp,
    // wait states and response code set by the bench
    input wire logic [3:0] stall,
    input wire logic [1:0] resp_sel
);
    logic [3:0] wait_q;
    logic [63:0] addr_log[$];
    logic [31:0] data_log[$];
    // ========================================
    // one-cycle ack after stall cycles
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wait_q <= 4'h0;
            mem_ack <= 1'b0;
            mem_resp <= 2'h0;
        end else if (mem_req && !mem_ack && wait_q >= stall) begin
            mem_ack <= 1'b1;
            mem_resp <= resp_sel;
            wait_q <= 4'h0;
            addr_log.push_back(mem_addr);
            data_log.push_back(mem_data);
        end else begin
            mem_ack <= 1'b0;
            // response only valid with ack, so never leave it steady
            mem_resp <= ~mem_resp;
            wait_q <= (mem_req && !mem_ack) ? wait_q + 4'h1 : 4'h0;
        end
    end
endmodule

// >>> trace_buffer_pointer_checks_test.sv
// self-checking bench of the trace buffer pointer checks
`timescale 1ns/1ps
`include "tbp_defines.svh"
module trace_buffer_pointer_checks_test;
    import tbp_pkg::*;
    localparam logic [63:0] BASE = 64'h1000;
    localparam logic [63:0] LIM = 64'h2000;
    // ========================================
    // design and partner signals
    logic hclk, hready, hreadyout, hresp, trace_ready, mem_req, mem_ack;
    logic hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, trace_valid = 1'b0;
    logic trace_trigger = 1'b0, owner_ns = 1'b0, owner_stage2 = 1'b0;
    logic [31:0] haddr = 0, hwdata = 0, trace_data = 0, hrdata, mem_data;
    logic [1:0] htrans = 0, resp_sel = 0, mem_space, mem_resp;
    logic [2:0] hsize = 3'h2;
    logic [3:0] stall = 0;
    logic [15:0] owner_partid = 0, mem_partid;
    logic [7:0] owner_pmg = 0, mem_pmg, mem_attr;
    logic mem_ns, mem_tag_unchecked, wrap_event_output;
    logic buffer_interrupt_output;
    tbp_addr_t mem_addr;
    // ========================================
    // bench model
    logic [63:0] m_ptr;
    logic [31:0] m_trg;
    logic [5:0] m_ec;
    logic m_stop, m_wrap, m_tdet, m_ld, m_flt;
    logic [63:0] exp_a[$];
    logic [31:0] exp_d[$];
    int error_cnt, checks;
    logic [63:0] ptrs[9] = '{64'h1000, 64'h1010, 64'h1010, 64'h1012,
        64'h0ff0, 64'h2000, 64'h0100_0000_0000_1000, 64'h1ffc, 64'h1100};
    logic [1:0] resps[9] = '{2'h0, 2'h2, 2'h1, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0,
        2'h0};
    logic [31:0] trgs[9] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
        32'h0, 32'h8};

    assign hready = hreadyout;
    tbp_trace_buffer #(.ALIGN_LOG2(2)) dut (.*);
    tbp_mem_model mem (.*);

    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end

    function automatic logic out_of_range(input logic [63:0] p);
        return p < BASE || p >= LIM || p[63:56] != BASE[63:56];
    endfunction

    task automatic check(input string what, input logic [63:0] seen,
        input logic [63:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // sel 0 ready, 1 trace taken, 2 memory idle
    task automatic wait_on(input int sel);
        int n;
        logic ok;
        n = 0;
        // sampled mid-cycle: the value the coming edge acts on
        do begin
            @(negedge hclk);
            ok = sel == 0 ? hreadyout : sel == 1 ? trace_ready : !mem_req;
            @(posedge hclk);
            n++;
        end while (ok !== 1'b1 && n < 300);
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("mismatch wait %0d expected 1 seen %b", sel, ok);
            test_done();
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a,
        input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        wait_on(0);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_on(0);
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask

    task automatic word;
        logic [31:0] d;
        d = $urandom;
        stall <= 4'($urandom_range(6));
        owner_partid <= 16'($urandom);
        owner_pmg <= 8'($urandom);
        owner_ns <= 1'($urandom);
        owner_stage2 <= 1'($urandom);
        trace_data <= d;
        trace_valid <= 1'b1;
        wait_on(1);
        trace_valid <= 1'b0;
        if (!m_stop) begin
            if (m_ptr[1:0] != 2'h0) begin
                m_ec = 6'h2;
                if (out_of_range(m_ptr)) m_ptr = BASE;
            end else begin
                if (out_of_range(m_ptr)) begin
                    m_ptr = BASE;
                    m_wrap = 1'b1;
                end
                exp_a.push_back(m_ptr);
                exp_d.push_back(d);
                if (resp_sel != 2'h0) begin
                    m_ec = resp_sel == 2'h1 ? 6'h3 : 6'h4;
                end else begin
                    m_ptr = m_ptr + 64'h4;
                    if (m_tdet && m_trg <= 32'h4) begin
                        m_trg = 32'h0;
                        m_ec = 6'h5;
                    end else if (m_tdet) begin
                        m_trg = m_trg - 32'h4;
                    end
                    if (m_ptr >= LIM) begin
                        m_ptr = BASE;
                        m_wrap = 1'b1;
                        m_ec = 6'h1;
                    end
                end
            end
            m_stop = m_ec != 6'h0;
        end
        repeat (2) @(posedge hclk);
        wait_on(2);
    endtask

    initial begin
        logic [31:0] r;
        logic [10:0] e;
        r = $urandom(29);
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        bus(1'b0, `TBP_OFF_ID, 32'h0, r);
        check("align field", r[3:0], 64'h2);
        bus(1'b0, 8'h28, 32'h0, r);
        check("unmapped", r, 64'h0);
        bus(1'b0, `TBP_OFF_STAT, 32'h0, r);
        check("status reset", r, 64'h0);
        wr(`TBP_OFF_BASE_LO, BASE[31:0]);
        // limit set first so each pointer load is judged against it
        wr(`TBP_OFF_LIM_LO, LIM[31:0]);
        $display("reset test done");
        for (int i = 0; i < 9; i++) begin
            wr(`TBP_OFF_PTR_LO, ptrs[i][31:0]);
            wr(`TBP_OFF_PTR_HI, ptrs[i][63:32]);
            wr(`TBP_OFF_TRG, trgs[i]);
            // enable in a write of its own
            wr(`TBP_OFF_LIM_LO, LIM[31:0] | {26'h0, i[0], 5'h1});
            resp_sel <= resps[i];
            trace_trigger <= trgs[i] != 32'h0;
            m_ptr = ptrs[i];
            m_ld = !out_of_range(ptrs[i]) && ptrs[i][1:0] == 2'h0;
            m_trg = trgs[i];
            m_tdet = trgs[i] != 32'h0;
            m_ec = 6'h0;
            m_stop = 1'b0;
            m_wrap = 1'b0;
            exp_a.delete();
            exp_d.delete();
            mem.addr_log.delete();
            mem.data_log.delete();
            word();
            word();
            trace_trigger <= 1'b0;
            wr(`TBP_OFF_PTR_LO, 32'h1500);
            check("irq out", buffer_interrupt_output, m_stop);
            bus(1'b0, `TBP_OFF_PTR_LO, 32'h0, r);
            if (m_ec != 6'h2) check("pointer", r, m_ptr[31:0]);
            wr(`TBP_OFF_LIM_LO, LIM[31:0] | {26'h0, i[0], 5'h0});
            bus(1'b0, `TBP_OFF_STAT, 32'h0, r);
            m_flt = m_ec == 6'h2 || m_ec == 6'h3;
            e = {m_ec, m_stop, m_wrap, m_ec == 6'h3, m_stop, m_ld && m_flt};
            check("status", {r[31:26], r[22], r[19:17], r[9]}, e);
            check("restart", r[8], m_ld && !m_flt);
            bus(1'b0, `TBP_OFF_TRG, 32'h0, r);
            check("countdown", r, m_trg);
            check("writes", mem.addr_log.size(), exp_a.size());
            foreach (exp_a[j]) check("addr", mem.addr_log[j], exp_a[j]);
            foreach (exp_d[j]) check("data", mem.data_log[j], exp_d[j]);
            wr(`TBP_OFF_STAT, 32'h0);
            @(posedge hclk);
            check("irq clear", buffer_interrupt_output, 1'b0);
            $display("test %0d done", i);
        end
        test_done();
    end
endmodule
